// ### src/mch_pkg.sv
// package for the modulus counter and holding register block
// assumes a 32-bit classic wishbone slave, one register per word
package mch_pkg;
   // ********************************
   // register map (index, byte = 4*index)
   // ********************************
   localparam logic [7:0] IDX_PA3_HOLD  = 8'hb2;
   localparam logic [7:0] IDX_PA2_HOLD  = 8'hb3;
   localparam logic [7:0] IDX_PA1_HOLD  = 8'hb4;
   localparam logic [7:0] IDX_PA0_HOLD  = 8'hb5;
   localparam logic [7:0] IDX_MOD_COUNT = 8'hb6;
   localparam logic [7:0] IDX_CAP0_HOLD = 8'hb8;
   localparam logic [7:0] IDX_CAP1_HOLD = 8'hba;
   localparam logic [7:0] IDX_CAP2_HOLD = 8'hbc;
   localparam logic [7:0] IDX_CAP3_HOLD = 8'hbe;
   localparam logic [7:0] IDX_CTRL      = 8'hc0;
   localparam logic [7:0] IDX_STATUS    = 8'hc1;
   // ********************************
   // control register fields
   // ********************************
   localparam int CTL_RDLOAD   = 0;
   localparam int CTL_LATCHM   = 1;
   localparam int CTL_HOLDING_BUFFER_ENABLE    = 2;
   localparam int CTL_MODMODE  = 3;
   localparam int CTL_FORCELD  = 4;
   localparam int CTL_MODCNT_ENABLE     = 5;
   localparam int CTL_TEN      = 6;
   localparam int CTL_STOPDBG  = 7;
   localparam int CTL_STOPWAIT = 8;
   localparam int CTL_ACCUM_A_WIDE_ENABLE     = 9;
   localparam int CTL_ACCUM_B_WIDE_ENABLE     = 10;
   localparam int CTL_PAXEN    = 11;
   localparam int CTL_WIDTH    = 15;
   localparam logic [14:0] CTL_RESET = 15'h0000;
   localparam int ST_ZF      = 0;
   localparam int ST_ZEROWR  = 1;
   localparam logic [1:0] PRE_RESET = 2'h0;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE  = 16'h0001;

   typedef struct packed {
      logic stop_mode;
      logic debug_mode;
      logic wait_mode;
   } mch_modes_t;
endpackage

// ### src/mch_modcount_hold.sv
// modulus down-counter, capture and pulse accumulator holding registers
// assumes capture and accumulator logic outside; counting tick from own prescaler, run by modulus enable
//
// Contract
// - four 8-bit accumulator holds, readable anytime, write-ignored, reset zero
// - four 16-bit capture holds latch capture values, read-only
// - count read gives live counter, or load value when select set
// - zero write with buffer and latch mode latches all holds
// - after zero write counter stays at zero, no zero flag
// - modulus mode write updates load only; count takes it at underflow
// - force-load copies load value into counter at once
// - non-modulus write clears prescaler, loads counter, counts once to zero
// - stop mode halts main timer and modulus counter
// - debug mode halts counters only when stop-in-debug set
// - wait mode halts counters only when stop-in-wait set
// - main timer enable clear stops timer operations, registers stay accessible
// - modulus enable clear stops the down-counter
// - accumulator A wide enable activates 16-bit A, else 8-bit 3 and 2
// - accumulator B wide enable activates 16-bit B, else 8-bit 1 and 0
// - latch on counter reaching zero moves values, clears 8-bit accumulators
// - queue mode capture moves old capture value into hold first
// - a hold counts as empty once software has read it
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
module mch_modcount_hold #(
   parameter int PRE_W = 2
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic [31:0]           adr_i,
   input  wire logic [31:0]           dat_i,
   output logic      [31:0]           dat_o,
   input  wire logic                  we_i,
   input  wire logic [3:0]            sel_i,
   input  wire logic                  cyc_i,
   input  wire logic                  stb_i,
   output logic                       ack_o,
   output logic                       err_o,
   input  wire logic                  stop_mode_i,
   input  wire logic                  debug_mode_i,
   input  wire logic                  wait_mode_i,
   input  wire logic [63:0]           capture_i,
   input  wire logic [3:0]            queue_capture_i,
   input  wire logic [31:0]           pulse_acc_i,
   output logic                       timer_run_o,
   output logic                       acc_a_wide_o,
   output logic                       acc_b_wide_o,
   output logic [3:0]                 narrow_acc_en_o,
   output logic                       latch_pulse_o,
   output logic                       clear_narrow_o,
   output logic [3:0]                 hold_empty_o,
   output logic                       prescale_clr_o,
   output logic [PRE_W-1:0]           prescale_o,
   output logic                       zero_flag_o
);
   // ********************************
   // mode inputs synchronised
   // ********************************
   mch_pkg::mch_modes_t modes_s1_r;
   mch_pkg::mch_modes_t modes_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         modes_s1_r <= '0;
         modes_r    <= '0;
      end else begin
         modes_s1_r <= '{stop_mode_i, debug_mode_i, wait_mode_i};
         modes_r    <= modes_s1_r;
      end
   end

   // ********************************
   // bus decode
   // ********************************
   logic [14:0]    ctrl_r;
   logic [15:0]    load_r;
   logic [15:0]    count_r;
   logic [7:0]     acc_hold_r [4];
   logic [15:0]    cap_hold_r [4];
   logic [PRE_W-1:0] pre_r;
   logic           zf_r;
   logic           zero_wr_r;
   logic           ack_r;
   logic           req;
   logic           wr_cnt;
   logic           wr_ctl;
   logic           wr_st;
   logic           known;
   logic [7:0]     idx;
   logic [31:0]    rdata;
   logic           run_mod;
   logic           tick;
   logic           latch_ev;
   logic [3:0]     rd_cap;

   assign idx = adr_i[9:2];
   assign req = cyc_i && stb_i && !ack_r;

   always_comb begin
      known = 1'b1;
      rdata = 32'h0000_0000;
      rd_cap = 4'h0;
      if (idx >= mch_pkg::IDX_PA3_HOLD && idx <= mch_pkg::IDX_PA0_HOLD) begin
         rdata = {24'h00_0000, acc_hold_r[idx[1:0] - 2'h2]};
      end else if (idx == mch_pkg::IDX_MOD_COUNT) begin
         rdata = {16'h0000, ctrl_r[mch_pkg::CTL_RDLOAD] ? load_r : count_r};
      end else if (idx[7:3] == 5'h17 && !idx[0]) begin
         rdata = {16'h0000, cap_hold_r[idx[2:1]]};
         rd_cap[idx[2:1]] = 1'b1;
      end else if (idx == mch_pkg::IDX_CTRL) begin
         rdata = {17'h0_0000, ctrl_r};
      end else if (idx == mch_pkg::IDX_STATUS) begin
         rdata = {30'h0000_0000, zero_wr_r, zf_r};
      end else begin
         known = 1'b0;
      end
   end

   // whole-word access only; partial lanes still write all 16 bits
   assign wr_cnt = req && we_i && known && idx == mch_pkg::IDX_MOD_COUNT;
   assign wr_ctl = req && we_i && idx == mch_pkg::IDX_CTRL;
   assign wr_st  = req && we_i && idx == mch_pkg::IDX_STATUS;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         err_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_r <= req && known;
         err_o <= req && !known;
         dat_o <= (req && known && !we_i) ? rdata : 32'h0000_0000;
      end
   end
   assign ack_o = ack_r;

   // ********************************
   // control register
   // ********************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= mch_pkg::CTL_RESET;
      end else if (wr_ctl) begin
         ctrl_r <= dat_i[14:0];
         ctrl_r[mch_pkg::CTL_FORCELD] <= 1'b0; // force-load reads back zero
      end
   end

   // ********************************
   // run gating for both counters
   // ********************************
   logic freeze;
   assign freeze = modes_r.stop_mode
      || (modes_r.debug_mode && ctrl_r[mch_pkg::CTL_STOPDBG])
      || (modes_r.wait_mode && ctrl_r[mch_pkg::CTL_STOPWAIT]);
   assign run_mod = !freeze && ctrl_r[mch_pkg::CTL_MODCNT_ENABLE];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_run_o     <= 1'b0;
         acc_a_wide_o    <= 1'b0;
         acc_b_wide_o    <= 1'b0;
         narrow_acc_en_o <= 4'h0;
      end else begin
         timer_run_o     <= !freeze && ctrl_r[mch_pkg::CTL_TEN];
         acc_a_wide_o    <= ctrl_r[mch_pkg::CTL_ACCUM_A_WIDE_ENABLE];
         acc_b_wide_o    <= ctrl_r[mch_pkg::CTL_ACCUM_B_WIDE_ENABLE];
         narrow_acc_en_o <= {ctrl_r[mch_pkg::CTL_ACCUM_A_WIDE_ENABLE] ? 2'h0 : ctrl_r[14:13],
                             ctrl_r[mch_pkg::CTL_ACCUM_B_WIDE_ENABLE] ? 2'h0 : ctrl_r[12:11]};
      end
   end

   // ********************************
   // prescaler and down-counter
   // ********************************
   assign tick = run_mod && (&pre_r);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_r <= PRE_W'(mch_pkg::PRE_RESET);
      end else if (wr_cnt && !ctrl_r[mch_pkg::CTL_MODMODE]) begin
         pre_r <= PRE_W'(mch_pkg::PRE_RESET);
      end else if (run_mod) begin
         pre_r <= pre_r + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         load_r <= mch_pkg::CNT_ZERO;
      end else if (wr_cnt) begin
         load_r <= dat_i[15:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_r   <= mch_pkg::CNT_ZERO;
         zero_wr_r <= 1'b0;
      end else if (wr_cnt && dat_i[15:0] == mch_pkg::CNT_ZERO) begin
         count_r   <= mch_pkg::CNT_ZERO;
         zero_wr_r <= 1'b1;
      end else if (wr_cnt && !ctrl_r[mch_pkg::CTL_MODMODE]) begin
         count_r   <= dat_i[15:0];
         zero_wr_r <= 1'b0;
      end else if (wr_ctl && dat_i[mch_pkg::CTL_FORCELD]) begin
         count_r   <= load_r;
         zero_wr_r <= load_r == mch_pkg::CNT_ZERO;
      end else if (tick && !zero_wr_r) begin
         if (count_r == mch_pkg::CNT_ONE && ctrl_r[mch_pkg::CTL_MODMODE]) begin
            count_r <= load_r;
            zero_wr_r <= load_r == mch_pkg::CNT_ZERO;
         end else if (count_r != mch_pkg::CNT_ZERO) begin
            count_r <= count_r - mch_pkg::CNT_ONE;
         end
      end
   end

   logic hit_zero;
   assign hit_zero = tick && !zero_wr_r && count_r == mch_pkg::CNT_ONE;

   // set wins over software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         zf_r <= 1'b0;
      end else if (hit_zero) begin
         zf_r <= 1'b1;
      end else if (wr_st && dat_i[mch_pkg::ST_ZF]) begin
         zf_r <= 1'b0;
      end
   end

   // ********************************
   // holding registers
   // ********************************
   logic latch_mode;
   assign latch_mode = ctrl_r[mch_pkg::CTL_HOLDING_BUFFER_ENABLE] && ctrl_r[mch_pkg::CTL_LATCHM];
   assign latch_ev = latch_mode && ((wr_cnt && dat_i[15:0] == mch_pkg::CNT_ZERO)
                                    || hit_zero);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 4; i++) begin
            acc_hold_r[i] <= 8'h00;
            cap_hold_r[i] <= 16'h0000;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (latch_ev) begin
               acc_hold_r[i] <= pulse_acc_i[8*(3-i) +: 8];
               cap_hold_r[i] <= capture_i[16*i +: 16];
            end else if (ctrl_r[mch_pkg::CTL_HOLDING_BUFFER_ENABLE] && !ctrl_r[mch_pkg::CTL_LATCHM]
                         && queue_capture_i[i]) begin
               cap_hold_r[i] <= capture_i[16*i +: 16];
            end
         end
      end
   end

   // hold becomes empty on read, full on any load
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_empty_o <= 4'hf;
      end else begin
         for (int i = 0; i < 4; i++) begin
            // latch mode ignores queue pulses, so they must not fill the hold
            if (latch_ev || (ctrl_r[mch_pkg::CTL_HOLDING_BUFFER_ENABLE] && !ctrl_r[mch_pkg::CTL_LATCHM]
                             && queue_capture_i[i])) begin
               hold_empty_o[i] <= 1'b0;
            end else if (req && !we_i && rd_cap[i]) begin
               hold_empty_o[i] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_pulse_o  <= 1'b0;
         clear_narrow_o <= 1'b0;
         prescale_clr_o <= 1'b0;
         prescale_o     <= '0;
         zero_flag_o    <= 1'b0;
      end else begin
         latch_pulse_o  <= latch_ev;
         clear_narrow_o <= latch_ev;
         prescale_clr_o <= wr_cnt && !ctrl_r[mch_pkg::CTL_MODMODE];
         prescale_o     <= pre_r;
         zero_flag_o    <= zf_r;
      end
   end

   // ********************************
   // checks
   // ********************************
   property p_zero_write_holds;
      @(posedge clk_i) disable iff (rst_i)
      (wr_cnt && dat_i[15:0] == 16'h0000) |=> (count_r == 16'h0000 && !hit_zero);
   endproperty
   a_zero_write_holds: assert property (p_zero_write_holds) else $error("zero write moved");

   property p_read_select;
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && idx == mch_pkg::IDX_MOD_COUNT) |=>
         dat_o[15:0] == ($past(ctrl_r[mch_pkg::CTL_RDLOAD]) ? $past(load_r) : $past(count_r));
   endproperty
   a_read_select: assert property (p_read_select) else $error("count read wrong");

   property p_zero_latch;
      @(posedge clk_i) disable iff (rst_i)
      (wr_cnt && dat_i[15:0] == 16'h0000 && latch_mode) |=> latch_pulse_o;
   endproperty
   a_zero_latch: assert property (p_zero_latch) else $error("no latch");

   property p_mod_write_load_only;
      @(posedge clk_i) disable iff (rst_i)
      (wr_cnt && ctrl_r[mch_pkg::CTL_MODMODE] && dat_i[15:0] != 16'h0000 && !tick) |=>
         (load_r == $past(dat_i[15:0]) && count_r == $past(count_r));
   endproperty
   a_mod_write_load_only: assert property (p_mod_write_load_only) else $error("load");

   property p_force_load;
      @(posedge clk_i) disable iff (rst_i)
      (wr_ctl && dat_i[mch_pkg::CTL_FORCELD] && !wr_cnt) |=> count_r == $past(load_r);
   endproperty
   a_force_load: assert property (p_force_load) else $error("force load");

   property p_oneshot;
      @(posedge clk_i) disable iff (rst_i)
      (wr_cnt && !ctrl_r[mch_pkg::CTL_MODMODE] && dat_i[15:0] != 16'h0000) |=>
         (count_r == $past(dat_i[15:0]) && pre_r == '0);
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("one shot load");

   property p_stop_halts;
      @(posedge clk_i) disable iff (rst_i)
      (modes_r.stop_mode && !wr_cnt && !wr_ctl) |=> $stable(count_r);
   endproperty
   a_stop_halts: assert property (p_stop_halts) else $error("ran in stop");

   property p_modcnt_enable_stop;
      @(posedge clk_i) disable iff (rst_i)
      (!ctrl_r[mch_pkg::CTL_MODCNT_ENABLE] && !wr_cnt && !wr_ctl) |=> $stable(count_r);
   endproperty
   a_modcnt_enable_stop: assert property (p_modcnt_enable_stop) else $error("ran disabled");

   // flag register first, output copy one clock later
   sequence s_hit_zero_settled;
      hit_zero ##1 1'b1;
   endsequence

   property p_underflow;
      @(posedge clk_i) disable iff (rst_i)
      s_hit_zero_settled |-> ##1 zero_flag_o;
   endproperty
   a_underflow: assert property (p_underflow) else $error("no zero flag");

   property p_read_empty;
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && rd_cap[0] && !latch_ev && !queue_capture_i[0]) |=> hold_empty_o[0];
   endproperty
   a_read_empty: assert property (p_read_empty) else $error("not empty");

   sequence s_count_latch;
      latch_mode && hit_zero;
   endsequence

   property p_count_latch;
      @(posedge clk_i) disable iff (rst_i)
      s_count_latch |=> (latch_pulse_o && clear_narrow_o);
   endproperty
   a_count_latch: assert property (p_count_latch) else $error("no latch at zero");

   property p_stop_timer;
      @(posedge clk_i) disable iff (rst_i)
      modes_r.stop_mode |=> !timer_run_o;
   endproperty
   a_stop_timer: assert property (p_stop_timer) else $error("timer ran in stop");
endmodule

// ### verification/mch_modcount_hold_tb_top.sv
// bench for the modulus counter and holding register block
// assumes mch_pkg is compiled first; design at its default prescaler width
`timescale 1ns/1ps
module mch_modcount_hold_tb_top;
   // ********************************
   // signals and constants
   // ********************************
   typedef struct packed {
      logic [7:0]  idx;
      logic        we;
      logic [31:0] exp;
      logic        er;
   } mch_row_t;
   localparam logic [31:0] C_RDL = 32'h1 << mch_pkg::CTL_RDLOAD;
   localparam logic [31:0] C_LAT = 32'h1 << mch_pkg::CTL_LATCHM;
   localparam logic [31:0] C_BUF = 32'h1 << mch_pkg::CTL_HOLDING_BUFFER_ENABLE;
   localparam logic [31:0] C_MOD = 32'h1 << mch_pkg::CTL_MODMODE;
   localparam logic [31:0] C_FLD = 32'h1 << mch_pkg::CTL_FORCELD;
   localparam logic [31:0] C_MCE = 32'h1 << mch_pkg::CTL_MODCNT_ENABLE;
   localparam logic [31:0] C_TEN = 32'h1 << mch_pkg::CTL_TEN;
   localparam logic [31:0] C_PA  = 32'h1 << mch_pkg::CTL_ACCUM_A_WIDE_ENABLE;
   localparam logic [31:0] C_PB  = 32'h1 << mch_pkg::CTL_ACCUM_B_WIDE_ENABLE;
   localparam logic [31:0] C_NAR = 32'hf << mch_pkg::CTL_PAXEN;
   localparam logic [63:0] CAP   = 64'h4d4c_3b3a_2928_1716;
   localparam logic [31:0] PAC   = 32'hd3c2_b1a0;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [31:0] adr_i = 32'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] pulse_acc_i = 32'h0;
   logic [63:0] capture_i = 64'h0;
   logic [3:0]  sel_i = 4'hf;
   logic [3:0]  queue_capture_i = 4'h0;
   logic        we_i = 1'b0;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        stop_mode_i = 1'b0;
   logic        debug_mode_i = 1'b0;
   logic        wait_mode_i = 1'b0;
   logic [31:0] dat_o;
   logic [3:0]  narrow_acc_en_o;
   logic [3:0]  hold_empty_o;
   logic [1:0]  prescale_o;
   logic        ack_o, err_o, timer_run_o, acc_a_wide_o, acc_b_wide_o;
   logic        latch_pulse_o, clear_narrow_o, prescale_clr_o, zero_flag_o;
   int          n_errors = 0;
   int          num_checks = 0;
   int          n_pclr = 0;
   int          n_latch = 0;
   int          n_clr = 0;

   initial forever #50 clk_i = ~clk_i;

   // pulses are counted so a test can look for one after the fact
   always @(posedge clk_i) begin
      if (prescale_clr_o === 1'b1) n_pclr++;
      if (latch_pulse_o === 1'b1) n_latch++;
      if (clear_narrow_o === 1'b1) n_clr++;
   end

   mch_modcount_hold #(.PRE_W(2)) i_mch_modcount_hold (
      .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
      .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
      .err_o(err_o), .stop_mode_i(stop_mode_i), .debug_mode_i(debug_mode_i),
      .wait_mode_i(wait_mode_i), .capture_i(capture_i),
      .queue_capture_i(queue_capture_i), .pulse_acc_i(pulse_acc_i),
      .timer_run_o(timer_run_o), .acc_a_wide_o(acc_a_wide_o),
      .acc_b_wide_o(acc_b_wide_o), .narrow_acc_en_o(narrow_acc_en_o),
      .latch_pulse_o(latch_pulse_o), .clear_narrow_o(clear_narrow_o),
      .hold_empty_o(hold_empty_o), .prescale_clr_o(prescale_clr_o),
      .prescale_o(prescale_o), .zero_flag_o(zero_flag_o));

   // ********************************
   // tasks
   // ********************************
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t value %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t flag %b, expected %b", $time, got, exp);
      end
   endtask

   // classic cycle; the wait is bounded so a silent slave cannot hang the run
   task automatic wb(input logic [7:0] idx, input logic we, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge clk_i);
      adr_i <= {22'h0, idx, 2'b00};
      we_i  <= we;
      dat_i <= wd;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
      rd = dat_o;
      er = err_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      if (n >= 20) begin
         n_errors++;
         $display("[ERR] %0t no bus answer", $time);
         conclude();
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
      logic [31:0] d;
      logic        e;
      wb(idx, 1'b1, wd, d, e);
   endtask

   task automatic rdv(input logic [7:0] idx, output logic [31:0] d);
      logic e;
      wb(idx, 1'b0, 32'h0, d, e);
   endtask

   // ********************************
   // main sequence
   // ********************************
   initial begin
      mch_row_t    rows[10];
      logic [6:0]  mrow[8];
      logic [31:0] d;
      logic [31:0] d2;
      logic        e;
      logic        run;
      logic        crun;
      int          n;
      int          p0;
      rows = '{'{mch_pkg::IDX_PA3_HOLD, 1'b0, 32'h0, 1'b0},
               '{mch_pkg::IDX_PA2_HOLD, 1'b0, 32'h0, 1'b0},
               '{mch_pkg::IDX_PA1_HOLD, 1'b0, 32'h0, 1'b0},
               '{mch_pkg::IDX_PA0_HOLD, 1'b0, 32'h0, 1'b0},
               '{mch_pkg::IDX_PA2_HOLD, 1'b1, 32'h0, 1'b0},
               '{mch_pkg::IDX_PA2_HOLD, 1'b0, 32'h0, 1'b0},
               '{mch_pkg::IDX_PA0_HOLD, 1'b1, 32'h0, 1'b0},
               '{mch_pkg::IDX_PA0_HOLD, 1'b0, 32'h0, 1'b0},
               '{8'h20, 1'b0, 32'h0, 1'b1},
               '{8'h20, 1'b1, 32'h0, 1'b1}};
      // ten modcnt_enable stop debug wait stopdbg stopwait
      mrow = '{7'b1100000, 7'b1110000, 7'b1101000, 7'b1101010,
               7'b1100100, 7'b1100101, 7'b1000000, 7'b0000000};
      repeat (3) @(posedge clk_i);
      chk_val({28'h0, hold_empty_o}, 32'hf);
      chk_bit(zero_flag_o, 1'b0);
      rst_i <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         wb(rows[i].idx, rows[i].we, 32'hffff_ffff, d, e);
         chk_bit(e, rows[i].er);
         if (!rows[i].we && !rows[i].er) chk_val(d, rows[i].exp);
      end
      $display("register table done");
      for (int i = 0; i < 4; i++) begin
         wr(mch_pkg::IDX_CTRL, C_NAR | (i[0] ? C_PA : 32'h0) | (i[1] ? C_PB : 32'h0));
         repeat (2) @(posedge clk_i);
         chk_bit(acc_a_wide_o, i[0]);
         chk_bit(acc_b_wide_o, i[1]);
         chk_val({28'h0, narrow_acc_en_o}, {28'h0, ~{i[0], i[0], i[1], i[1]}});
      end
      $display("accumulator width done");
      // one-shot count from 3
      wr(mch_pkg::IDX_CTRL, C_TEN | C_MCE);
      p0 = n_pclr;
      wr(mch_pkg::IDX_MOD_COUNT, 32'h3);
      rdv(mch_pkg::IDX_MOD_COUNT, d);
      chk_bit(n_pclr > p0, 1'b1);
      chk_bit(d[15:0] <= 16'h3 && d[15:0] != 16'h0, 1'b1);
      // prescaler restarts at the write, counts each clock; output lags one clock
      chk_val({30'h0, prescale_o}, 32'h2);
      repeat (30) @(posedge clk_i);
      chk_bit(zero_flag_o, 1'b1);
      repeat (30) @(posedge clk_i);
      rdv(mch_pkg::IDX_MOD_COUNT, d);
      chk_val(d, 32'h0);
      wr(mch_pkg::IDX_STATUS, 32'h1);
      repeat (2) @(posedge clk_i);
      chk_bit(zero_flag_o, 1'b0);
      $display("one-shot done");
      // modulus mode: load only, force load, reload at underflow
      wr(mch_pkg::IDX_CTRL, C_TEN | C_MCE | C_MOD);
      wr(mch_pkg::IDX_MOD_COUNT, 32'h28);
      wr(mch_pkg::IDX_CTRL, C_TEN | C_MCE | C_MOD | C_FLD);
      rdv(mch_pkg::IDX_MOD_COUNT, d);
      chk_bit(d[15:0] >= 16'h20 && d[15:0] <= 16'h28, 1'b1);
      wr(mch_pkg::IDX_MOD_COUNT, 32'h9);
      rdv(mch_pkg::IDX_MOD_COUNT, d);
      chk_bit(d[15:0] >= 16'h10 && d[15:0] <= 16'h28, 1'b1);
      wr(mch_pkg::IDX_CTRL, C_TEN | C_MCE | C_MOD | C_RDL);
      rdv(mch_pkg::IDX_MOD_COUNT, d);
      chk_val(d, 32'h9);
      wr(mch_pkg::IDX_CTRL, C_TEN | C_MCE | C_MOD);
      n = 0;
      while (zero_flag_o !== 1'b1 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      chk_bit(n < 400, 1'b1);
      if (n >= 400) conclude();
      rdv(mch_pkg::IDX_MOD_COUNT, d);
      chk_bit(d[15:0] >= 16'h5 && d[15:0] <= 16'h9, 1'b1);
      wr(mch_pkg::IDX_STATUS, 32'h1);
      $display("modulus mode done");
      // halting by modes and enables; the count is reloaded high so no wrap intrudes
      wr(mch_pkg::IDX_MOD_COUNT, 32'hc8);
      wr(mch_pkg::IDX_CTRL, C_TEN | C_MCE | C_MOD | C_FLD);
      for (int i = 0; i < 8; i++) begin
         wr(mch_pkg::IDX_CTRL, C_MOD | (mrow[i][6] ? C_TEN : 32'h0) | (mrow[i][5] ? C_MCE : 32'h0)
            | ({31'h0, mrow[i][1]} << mch_pkg::CTL_STOPDBG)
            | ({31'h0, mrow[i][0]} << mch_pkg::CTL_STOPWAIT));
         stop_mode_i  <= mrow[i][4];
         debug_mode_i <= mrow[i][3];
         wait_mode_i  <= mrow[i][2];
         repeat (5) @(posedge clk_i);
         run  = !mrow[i][4] && !(mrow[i][3] && mrow[i][1]) && !(mrow[i][2] && mrow[i][0]);
         crun = run && mrow[i][5];
         chk_bit(timer_run_o, run && mrow[i][6]);
         rdv(mch_pkg::IDX_MOD_COUNT, d);
         repeat (20) @(posedge clk_i);
         rdv(mch_pkg::IDX_MOD_COUNT, d2);
         chk_bit(d !== d2, crun);
      end
      stop_mode_i  <= 1'b0;
      debug_mode_i <= 1'b0;
      wait_mode_i  <= 1'b0;
      $display("modes done");
      // queue mode on channel 2
      wr(mch_pkg::IDX_CTRL, C_BUF);
      capture_i <= CAP;
      queue_capture_i <= 4'h4;
      @(posedge clk_i);
      queue_capture_i <= 4'h0;
      capture_i <= ~CAP;
      repeat (3) @(posedge clk_i);
      chk_bit(hold_empty_o[2], 1'b0);
      rdv(mch_pkg::IDX_CAP2_HOLD, d);
      chk_val(d, {16'h0, CAP[47:32]});
      repeat (2) @(posedge clk_i);
      chk_bit(hold_empty_o[2], 1'b1);
      $display("queue done");
      // zero write in latch mode
      capture_i <= CAP;
      pulse_acc_i <= PAC;
      wr(mch_pkg::IDX_CTRL, C_BUF | C_LAT | C_NAR | C_TEN | C_MCE);
      p0 = n_latch;
      n = n_clr;
      wr(mch_pkg::IDX_MOD_COUNT, 32'h0);
      repeat (3) @(posedge clk_i);
      chk_bit(n_latch > p0, 1'b1);
      chk_bit(n_clr > n, 1'b1);
      for (int i = 0; i < 4; i++) begin
         rdv(mch_pkg::IDX_PA3_HOLD + 8'(i), d);
         chk_val(d, {24'h0, PAC[31-8*i -: 8]});
         rdv(mch_pkg::IDX_CAP0_HOLD + 8'(2*i), d);
         chk_val(d, {16'h0, CAP[16*i +: 16]});
      end
      repeat (40) @(posedge clk_i);
      rdv(mch_pkg::IDX_MOD_COUNT, d);
      chk_val(d, 32'h0);
      chk_bit(zero_flag_o, 1'b0);
      // latch again by counting down to zero, with new capture values
      capture_i <= ~CAP;
      p0 = n_latch;
      wr(mch_pkg::IDX_MOD_COUNT, 32'h2);
      repeat (20) @(posedge clk_i);
      chk_bit(n_latch > p0, 1'b1);
      rdv(mch_pkg::IDX_CAP1_HOLD, d);
      chk_val(d, {16'h0, ~CAP[31:16]});
      chk_bit(zero_flag_o, 1'b1);
      $display("latch done");
      // second reset in mid-run
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk_val({28'h0, hold_empty_o}, 32'hf);
      chk_bit(timer_run_o, 1'b0);
      rdv(mch_pkg::IDX_PA3_HOLD, d);
      chk_val(d, 32'h0);
      $display("reset done");
      conclude();
   end
endmodule
